// ---- shared/pbg_cfg.svh ----
// Address map, field positions, reset values and timing of the glue logic
`ifndef PBG_CFG_SVH
`define PBG_CFG_SVH
`define PBG_APB_AW        8
`define PBG_ADDR_CTRL     8'h00
`define PBG_ADDR_STATUS   8'h04
`define PBG_ADDR_MASK     8'h08
`define PBG_ADDR_CTC_ACK  8'h0C
`define PBG_ADDR_CTC0     8'h10
`define PBG_ADDR_STRIDE   8'h04
`define PBG_CTRL_START    0
`define PBG_CTRL_ABORT    1
`define PBG_ST_RUN        0
`define PBG_ST_DONE       1
`define PBG_ST_FAULT      2
`define PBG_ST_POR        3
`define PBG_ST_LVL_LO     8
`define PBG_ST_LVL_HI     10
`define PBG_CTC_EN_BIT    16
`define PBG_MASK_RST      7'h00
`define PBG_IRQ_LINES     7
`define PBG_LINE_SIX      5
`define PBG_CTC_NUM       3
`define PBG_CTC_W         16
`define PBG_ROM_LO        16
`define PBG_ROM_HI        18
`define PBG_RAM_LO        14
`define PBG_RAM_HI        16
`define PBG_RGN_BIT       20
`define PBG_RAM_PAIR0     3'h0
`define PBG_RAM_PAIR1     3'h1
`define PBG_MASK_LATCH    3'h2
`define PBG_CTC_UNIT      3'h3
`define PBG_BUF_BP_DATA   0
`define PBG_BUF_BP_ADDR   1
`define PBG_BUF_LC_DATA   2
`define PBG_BUF_LC_ADDR   3
`define PBG_CLK_MHZ       25
`define PBG_POR_DELAY_MS  5
`define PBG_POR_PULSE_MS  175
`define PBG_BERR_US       10
`define PBG_POR_CW        23
`define PBG_BERR_CW       12
`endif

// ---- shared/pbg_pkg.sv ----
// Types shared by the processor board glue logic
package pbg_pkg;
  typedef logic [2:0] pbg_lvl_t;
  typedef logic [3:0] pbg_buf_t;
  typedef enum logic [1:0] {ACQ_IDLE, ACQ_RUN, ACQ_COPY} pbg_acq_t;
  typedef enum logic [1:0] {POR_WAIT, POR_PULSE, POR_DONE} pbg_por_t;
endpackage

// ---- design/pbg_prio.sv ----
// Seven-to-three priority encoder, highest line number wins
`timescale 1ns/1ps
module pbg_prio #(
  parameter int N = 7
) (
  input  wire logic [N-1:0] masked_n,
  output pbg_pkg::pbg_lvl_t level
);
  import pbg_pkg::*;
  always_comb begin
    level = 3'h0;
    for (int i = 0; i < N; i++) begin
      if (!masked_n[i]) begin
        level = 3'(i + 1); // RULE19
      end
    end
  end
endmodule

// ---- design/pbg_ctc.sv ----
// Three programmable down counters with sticky terminal-count flags
`timescale 1ns/1ps
module pbg_ctc #(
  parameter int N = 3,
  parameter int W = 16
) (
  input  wire logic           mclk,
  input  wire logic           resetn,
  input  wire logic [N-1:0]   wr_en,
  input  wire logic [W-1:0]   wr_reload,
  input  wire logic           wr_run,
  input  wire logic [N-1:0]   ack,
  output logic      [N*W-1:0] count,
  output logic      [N-1:0]   flag
);
  import pbg_pkg::*;
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : gen_ctr
      logic [W-1:0] reload_q;
      logic [W-1:0] cnt_q;
      logic         run_q;
      always_ff @(posedge mclk) begin
        if (!resetn) begin
          reload_q <= '0;
          cnt_q    <= '0;
          run_q    <= 1'b0;
        end else if (wr_en[g]) begin
          reload_q <= wr_reload; // RULE2
          cnt_q    <= wr_reload;
          run_q    <= wr_run;
        end else if (run_q) begin
          cnt_q <= (cnt_q == '0) ? reload_q : cnt_q - 1'b1;
        end
      end
      always_ff @(posedge mclk) begin
        if (!resetn) begin
          flag[g] <= 1'b0;
        end else if (run_q && !wr_en[g] && cnt_q == '0) begin
          flag[g] <= 1'b1; // RULE2
        end else if (ack[g]) begin
          flag[g] <= 1'b0;
        end
      end
      assign count[g*W +: W] = cnt_q;
    end
  endgenerate
endmodule

// ---- design/pbg_top.sv ----
// Processor board glue: interrupts, decode, bus error, acquisition, reset
`timescale 1ns/1ps
`include "pbg_cfg.svh"
// Contract
// RULE1: Start acquisition, await done, then copy
// RULE2: Three programmable readable counters raise interrupts
// RULE3: Counters ORed, then ORed with line six
// RULE4: Request lines idle high; unmasked follow requests
// RULE5: Mask bit one forces masked line high
// RULE6: Seven masked lines encode to three bits
// RULE7: Interrupts vector to a fixed location
// RULE8: Bus request and grant held fixed
// RULE9: Exactly one buffer group enabled per access
// RULE10: Address bits 16-18 select ROM pair
// RULE11: Address bits 14-16 select RAM, mask, counters
// RULE12: Top address bit selects backplane or local
// RULE13: Addressed board acks, clearing bus-error timer
// RULE14: Timer expiry without ack raises bus fault
// RULE15: Byte devices paired into 16-bit words
// RULE16: 16-bit data, 23-bit address, 3 level lines
// RULE17: Power-on reset puts processor in known state
// RULE18: Reset pulse 175 ms, starting 5 ms later
// RULE19: Highest-numbered active line has top priority
// RULE20: Mask clears to zero on reset
module pbg_top #(
  parameter int unsigned POR_DELAY_CYC =
    `PBG_POR_DELAY_MS * `PBG_CLK_MHZ * 1000,
  parameter int unsigned POR_PULSE_CYC =
    `PBG_POR_PULSE_MS * `PBG_CLK_MHZ * 1000,
  parameter int unsigned BERR_CYC      = `PBG_BERR_US * `PBG_CLK_MHZ
) (
  input  wire logic                    mclk,
  input  wire logic                    resetn,
  input  wire logic [`PBG_APB_AW-1:0]  paddr,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic [6:0]              backplane_irq_lines_n,
  input  wire logic                    acquire_finished_flag,
  output logic                         acquire_run_bit,
  output logic                         copy_start,
  input  wire logic [22:1]             cpu_word_addr,
  input  wire logic                    backplane_space_select,
  input  wire logic                    cpu_addr_strobe_n,
  input  wire logic                    cpu_data_strobe_n,
  input  wire logic [1:0]              cpu_byte_strobe_n,
  input  wire logic                    cpu_int_ack,
  input  wire logic                    transfer_ack_n,
  output pbg_pkg::pbg_lvl_t            cpu_irq_level,
  output logic                         cpu_autovector_n,
  output logic                         cpu_ack_n,
  output logic                         cpu_reset_n,
  output logic                         bus_fault,
  output logic                         bus_request_n,
  output logic                         bus_grant_n,
  output logic      [7:0]              rom_pair_sel_n,
  output logic      [1:0]              ram_pair_sel_n,
  output logic      [1:0]              byte_lane_en_n,
  output logic                         mask_latch_sel_n,
  output logic                         ctc_sel_n,
  output pbg_pkg::pbg_buf_t            buf_en_n
);
  import pbg_pkg::*;
  localparam int SW = 37;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [SW-1:0] meta_q;
  logic [SW-1:0] sync_q;
  logic [6:0]    irq_s;
  logic          fin_s;
  logic          ack_n_s;
  logic          as_n_s;
  logic          ds_n_s;
  logic          iack_s;
  logic          a23_s;
  logic [22:1]   addr_s;
  logic [1:0]    bs_n_s;
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      meta_q <= {{10{1'b1}}, 25'h0, 2'h3};
      sync_q <= {{10{1'b1}}, 25'h0, 2'h3};
    end else begin
      meta_q <= {backplane_irq_lines_n, transfer_ack_n, cpu_addr_strobe_n,
                 cpu_data_strobe_n, acquire_finished_flag, cpu_int_ack,
                 backplane_space_select, cpu_word_addr, cpu_byte_strobe_n};
      sync_q <= meta_q;
    end
  end
  assign {irq_s, ack_n_s, as_n_s, ds_n_s, fin_s, iack_s, a23_s, addr_s,
          bs_n_s} = sync_q;

  ////////////////////////////////////////////////////////////////////////////
  // APB slave
  logic        access;
  logic        wr_done;
  logic        hit;
  logic [31:0] rd_d;
  logic [6:0]  mask_q;
  logic        done_q;
  logic        fault_seen_q;
  logic [`PBG_CTC_NUM-1:0] ctc_wr;
  logic [`PBG_CTC_NUM-1:0] ctc_ack;
  logic [`PBG_CTC_NUM-1:0] ctc_flag;
  logic [`PBG_CTC_NUM*`PBG_CTC_W-1:0] ctc_count;
  pbg_acq_t    acq_q;
  pbg_por_t    por_q;
  assign access  = psel && penable;
  assign wr_done = access && pready && pwrite && hit;
  always_comb begin
    hit  = 1'b1;
    rd_d = 32'h0;
    ctc_wr  = '0;
    ctc_ack = '0;
    case (paddr)
      `PBG_ADDR_CTRL:    rd_d = 32'h0;
      `PBG_ADDR_STATUS: begin
        rd_d[`PBG_ST_RUN]   = acquire_run_bit;
        rd_d[`PBG_ST_DONE]  = done_q;
        rd_d[`PBG_ST_FAULT] = fault_seen_q;
        rd_d[`PBG_ST_POR]   = (por_q != POR_DONE);
        rd_d[`PBG_ST_LVL_HI:`PBG_ST_LVL_LO] = cpu_irq_level;
      end
      `PBG_ADDR_MASK:    rd_d[6:0] = mask_q;
      `PBG_ADDR_CTC_ACK: rd_d[`PBG_CTC_NUM-1:0] = ctc_flag;
      default: begin
        hit = 1'b0;
        for (int i = 0; i < `PBG_CTC_NUM; i++) begin
          if (paddr == 8'(`PBG_ADDR_CTC0 + i * `PBG_ADDR_STRIDE)) begin
            hit = 1'b1;
            rd_d[`PBG_CTC_W-1:0] = ctc_count[i*`PBG_CTC_W +: `PBG_CTC_W];
            ctc_wr[i] = access && pready && pwrite; // RULE2
          end
        end
      end
    endcase
    if (access && pready && pwrite && paddr == `PBG_ADDR_CTC_ACK) begin
      ctc_ack = pwdata[`PBG_CTC_NUM-1:0];
    end
  end
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= access && !pready;
      pslverr <= access && !pready && !hit;
      if (access && !pready) begin
        prdata <= pwrite ? 32'h0 : rd_d;
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      mask_q <= `PBG_MASK_RST; // RULE20
    end else if (wr_done && paddr == `PBG_ADDR_MASK) begin
      mask_q <= pwdata[6:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter-timer unit
  pbg_ctc #(
    .N (`PBG_CTC_NUM),
    .W (`PBG_CTC_W)
  ) u_ctc (
    .mclk      (mclk),
    .resetn    (resetn),
    .wr_en     (ctc_wr),
    .wr_reload (pwdata[`PBG_CTC_W-1:0]),
    .wr_run    (pwdata[`PBG_CTC_EN_BIT]),
    .ack       (ctc_ack),
    .count     (ctc_count),
    .flag      (ctc_flag)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt gathering, masking and encoding
  logic [6:0] req_n;
  logic [6:0] masked_n;
  pbg_lvl_t   level;
  always_comb begin
    req_n = irq_s;
    req_n[`PBG_LINE_SIX] = irq_s[`PBG_LINE_SIX] & ~(|ctc_flag); // RULE3
    masked_n = req_n | mask_q; // RULE4 RULE5
  end
  pbg_prio #(
    .N (`PBG_IRQ_LINES)
  ) u_prio (
    .masked_n (masked_n),
    .level    (level)
  );
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cpu_irq_level    <= 3'h0;
      cpu_autovector_n <= 1'b1;
    end else begin
      cpu_irq_level    <= level; // RULE6 RULE16
      cpu_autovector_n <= !iack_s; // RULE7
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus ownership and address decode
  logic as_act;
  logic bp_cyc;
  logic lc_cyc;
  logic ram_rgn;
  logic [2:0] ram_fn;
  assign as_act  = !as_n_s;
  assign bp_cyc  = as_act && a23_s; // RULE12
  assign lc_cyc  = as_act && !a23_s;
  assign ram_rgn = lc_cyc && addr_s[`PBG_RGN_BIT];
  assign ram_fn  = addr_s[`PBG_RAM_HI:`PBG_RAM_LO];
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      bus_request_n <= 1'b1;
      bus_grant_n   <= 1'b0;
    end else begin
      bus_request_n <= 1'b1; // RULE8
      bus_grant_n   <= 1'b0;
    end
  end
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rom_pair_sel_n   <= 8'hFF;
      ram_pair_sel_n   <= 2'h3;
      mask_latch_sel_n <= 1'b1;
      ctc_sel_n        <= 1'b1;
      byte_lane_en_n   <= 2'h3;
      buf_en_n         <= 4'hF;
    end else begin
      rom_pair_sel_n <= 8'hFF;
      if (lc_cyc && !addr_s[`PBG_RGN_BIT]) begin
        rom_pair_sel_n[addr_s[`PBG_ROM_HI:`PBG_ROM_LO]] <= 1'b0; // RULE10
      end
      ram_pair_sel_n[0] <= !(ram_rgn && ram_fn == `PBG_RAM_PAIR0); // RULE11
      ram_pair_sel_n[1] <= !(ram_rgn && ram_fn == `PBG_RAM_PAIR1);
      mask_latch_sel_n  <= !(ram_rgn && ram_fn == `PBG_MASK_LATCH);
      ctc_sel_n         <= !(ram_rgn && ram_fn == `PBG_CTC_UNIT);
      byte_lane_en_n    <= as_act ? bs_n_s : 2'h3; // RULE15
      buf_en_n <= 4'hF;
      if (as_act) begin
        if (a23_s) begin
          buf_en_n[ds_n_s ? `PBG_BUF_BP_ADDR : `PBG_BUF_BP_DATA] <= 1'b0;
        end else begin
          buf_en_n[ds_n_s ? `PBG_BUF_LC_ADDR : `PBG_BUF_LC_DATA] <= 1'b0;
        end // RULE9
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transfer acknowledge and bus-error timer
  logic [`PBG_BERR_CW-1:0] berr_cnt_q;
  always_ff @(posedge mclk) begin
    if (!resetn || !bp_cyc || !ack_n_s) begin
      berr_cnt_q <= '0; // RULE13
    end else if (berr_cnt_q != `PBG_BERR_CW'(BERR_CYC)) begin
      berr_cnt_q <= berr_cnt_q + 1'b1;
    end
  end
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      bus_fault <= 1'b0;
      cpu_ack_n <= 1'b1;
    end else begin
      bus_fault <= bp_cyc && ack_n_s &&
                   berr_cnt_q == `PBG_BERR_CW'(BERR_CYC); // RULE14
      cpu_ack_n <= lc_cyc ? 1'b0 : !(bp_cyc && !ack_n_s);
    end
  end
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      fault_seen_q <= 1'b0;
    end else if (bus_fault) begin
      fault_seen_q <= 1'b1;
    end else if (wr_done && paddr == `PBG_ADDR_STATUS &&
                 pwdata[`PBG_ST_FAULT]) begin
      fault_seen_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Acquisition sequencing
  logic start_wr;
  assign start_wr = wr_done && paddr == `PBG_ADDR_CTRL &&
                    pwdata[`PBG_CTRL_START];
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      acq_q           <= ACQ_IDLE;
      acquire_run_bit <= 1'b0;
      copy_start      <= 1'b0;
    end else begin
      copy_start <= 1'b0;
      unique case (acq_q)
        ACQ_IDLE: if (start_wr) begin
          acq_q           <= ACQ_RUN;
          acquire_run_bit <= 1'b1; // RULE1
        end
        ACQ_RUN: if (fin_s || (wr_done && paddr == `PBG_ADDR_CTRL &&
                               pwdata[`PBG_CTRL_ABORT])) begin
          acq_q           <= fin_s ? ACQ_COPY : ACQ_IDLE;
          acquire_run_bit <= 1'b0;
        end
        ACQ_COPY: begin
          acq_q      <= ACQ_IDLE;
          copy_start <= 1'b1; // RULE1
        end
      endcase
    end
  end
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      done_q <= 1'b0;
    end else if (acq_q == ACQ_RUN && fin_s) begin
      done_q <= 1'b1;
    end else if (wr_done && paddr == `PBG_ADDR_STATUS &&
                 pwdata[`PBG_ST_DONE]) begin
      done_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Processor power-on reset pulse
  logic [`PBG_POR_CW-1:0] por_cnt_q;
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      por_q       <= POR_WAIT;
      por_cnt_q   <= '0;
      cpu_reset_n <= 1'b1;
    end else begin
      unique case (por_q)
        POR_WAIT: if (por_cnt_q == `PBG_POR_CW'(POR_DELAY_CYC - 1)) begin
          por_q       <= POR_PULSE; // RULE18
          por_cnt_q   <= '0;
          cpu_reset_n <= 1'b0; // RULE17
        end else begin
          por_cnt_q <= por_cnt_q + 1'b1;
        end
        POR_PULSE: if (por_cnt_q == `PBG_POR_CW'(POR_PULSE_CYC - 1)) begin
          por_q       <= POR_DONE;
          cpu_reset_n <= 1'b1; // RULE18
        end else begin
          por_cnt_q <= por_cnt_q + 1'b1;
        end
        POR_DONE: por_q <= POR_DONE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  AST_ALL_MASKED: assert property ( // RULE5
    (&mask_q) |=> cpu_irq_level == 3'h0)
    else $error("masked lines still raise a level");
  AST_FOLLOW: assert property ( // RULE4
    (mask_q == 7'h00 && !irq_s[6]) |=> cpu_irq_level == 3'h7)
    else $error("unmasked line seven not presented");
  AST_PRIO: assert property ( // RULE19
    (!masked_n[2] && masked_n[6:3] == 4'hF) |=> cpu_irq_level == 3'h3)
    else $error("wrong priority order");
  AST_CTC_OR: assert property ( // RULE3
    ((|ctc_flag) && !mask_q[5] && masked_n[6]) |=> cpu_irq_level == 3'h6)
    else $error("counter interrupt not on line six");
  AST_ROM_ONE: assert property ( // RULE10
    $onehot0(~rom_pair_sel_n))
    else $error("more than one ROM pair selected");
  AST_BUF_ONE: assert property ( // RULE9
    as_act |=> $onehot(~buf_en_n))
    else $error("buffer enables not one-hot");
  AST_LOCAL: assert property ( // RULE12
    lc_cyc |=> buf_en_n[`PBG_BUF_BP_DATA] && buf_en_n[`PBG_BUF_BP_ADDR])
    else $error("local access opened backplane buffers");
  AST_ACK_CLR: assert property ( // RULE13
    (bp_cyc && !ack_n_s) |=> berr_cnt_q == '0)
    else $error("acknowledge did not clear timer");
  AST_BERR: assert property ( // RULE14
    $rose(bus_fault) |-> $past(bp_cyc) && $past(ack_n_s) &&
      $past(berr_cnt_q) == `PBG_BERR_CW'(BERR_CYC))
    else $error("bus fault without timer expiry");
  AST_ACQ: assert property ( // RULE1
    (acq_q == ACQ_RUN && fin_s) |=> !acquire_run_bit ##1 copy_start)
    else $error("copy not started after done");
  AST_POR: assert property ( // RULE17
    $fell(cpu_reset_n) |-> $past(por_q) == POR_WAIT)
    else $error("reset pulse out of sequence");
  COV_ACQ: cover property (start_wr ##[1:1000] copy_start);
  COV_FAULT: cover property ($rose(bus_fault));
  COV_IRQ: cover property ((|ctc_flag) ##1 cpu_irq_level == 3'h6);
endmodule

// ---- test/pbg_bp_model.sv ----
// Backplane boards model: timebase done flag, acknowledge, requests
`timescale 1ns/1ps
module pbg_bp_model (
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  wire logic       acquire_run_bit,
  input  wire logic       cpu_addr_strobe_n,
  input  wire logic       backplane_space_select,
  input  wire logic [7:0] ack_delay,
  input  wire logic       ack_mute,
  input  wire logic [7:0] done_delay,
  input  wire logic [6:0] irq_req,
  output logic      [6:0] backplane_irq_lines_n,
  output logic            acquire_finished_flag,
  output logic            transfer_ack_n
);
  logic [7:0] ack_cnt_q;
  logic [7:0] done_cnt_q;
  logic       run_q;
  logic       ack_n_q;
  logic       done_q;
  ////////////////////////////////////////////////////////////////////////
  // Lines idle high, pulled low while requested
  assign backplane_irq_lines_n = ~irq_req;
  assign transfer_ack_n        = ack_n_q;
  assign acquire_finished_flag = done_q;
  ////////////////////////////////////////////////////////////////////////
  // Acknowledge after delay, released to pull-up level
  always_ff @(posedge mclk) begin
    if (!resetn || cpu_addr_strobe_n || !backplane_space_select) begin
      ack_cnt_q <= 8'h00;
      ack_n_q   <= 1'b1;
    end else if (!ack_mute && ack_cnt_q >= ack_delay) begin
      ack_n_q <= 1'b0;
    end else begin
      ack_cnt_q <= ack_cnt_q + 8'h01;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Done flag some cycles after run rises
  always_ff @(posedge mclk) begin
    run_q <= resetn && acquire_run_bit;
    if (!resetn || (acquire_run_bit && !run_q)) begin
      done_q     <= 1'b0;
      done_cnt_q <= 8'h00;
    end else if (acquire_run_bit && !done_q) begin
      if (done_cnt_q >= done_delay)
        done_q <= 1'b1;
      else
        done_cnt_q <= done_cnt_q + 8'h01;
    end
  end
endmodule

// ---- test/test_pbg_top.sv ----
// Self-checking bench for the processor board glue logic
`timescale 1ns/1ps
`include "pbg_cfg.svh"
module test_pbg_top;
  import pbg_pkg::*;
  logic        mclk, resetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr, ack_delay, done_delay, rom_pair_sel_n;
  logic [31:0] pwdata, prdata, rd;
  logic [6:0]  backplane_irq_lines_n, irq_req;
  logic        acquire_finished_flag, acquire_run_bit, copy_start;
  logic        backplane_space_select, cpu_addr_strobe_n, cpu_data_strobe_n;
  logic [1:0]  cpu_byte_strobe_n, ram_pair_sel_n, byte_lane_en_n;
  logic        cpu_int_ack, transfer_ack_n, ack_mute, cpu_autovector_n;
  logic        cpu_ack_n, cpu_reset_n, bus_fault, bus_request_n;
  logic        bus_grant_n, mask_latch_sel_n, ctc_sel_n;
  logic [22:1] cpu_word_addr;
  pbg_lvl_t    cpu_irq_level;
  pbg_buf_t    buf_en_n;
  int          n_mismatch, n_compared, n;
  logic [3:0]  ram_exp [4] = '{4'hB, 4'h7, 4'hD, 4'hE};

  pbg_top #(.POR_DELAY_CYC(4), .POR_PULSE_CYC(8), .BERR_CYC(8)) i_pbg_top (
    .mclk, .resetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .backplane_irq_lines_n, .acquire_finished_flag,
    .acquire_run_bit, .copy_start, .cpu_word_addr, .backplane_space_select,
    .cpu_addr_strobe_n, .cpu_data_strobe_n, .cpu_byte_strobe_n,
    .cpu_int_ack, .transfer_ack_n, .cpu_irq_level, .cpu_autovector_n,
    .cpu_ack_n, .cpu_reset_n, .bus_fault, .bus_request_n, .bus_grant_n,
    .rom_pair_sel_n, .ram_pair_sel_n, .byte_lane_en_n, .mask_latch_sel_n,
    .ctc_sel_n, .buf_en_n);

  pbg_bp_model i_pbg_bp_model (
    .mclk, .resetn, .acquire_run_bit, .cpu_addr_strobe_n,
    .backplane_space_select, .ack_delay, .ack_mute, .done_delay, .irq_req,
    .backplane_irq_lines_n, .acquire_finished_flag, .transfer_ack_n);
  ////////////////////////////////////////////////////////////////////////
  // Clock, compare, bus and processor cycle tasks
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] wd);
    int k;
    @(posedge mclk);
    psel   <= 1'b1;
    paddr  <= a;
    pwrite <= w;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    chk(32'(k), 32'd2);
  endtask

  task automatic cpu(input logic bp, input logic [22:1] a,
                     input logic ds, input logic ia);
    @(posedge mclk);
    backplane_space_select <= bp;
    cpu_word_addr          <= a;
    cpu_addr_strobe_n      <= 1'b0;
    cpu_data_strobe_n      <= ds;
    cpu_byte_strobe_n      <= {1'b1, ds};
    cpu_int_ack            <= ia;
    repeat (8) @(posedge mclk);
  endtask

  task automatic idle;
    cpu_addr_strobe_n <= 1'b1;
    cpu_data_strobe_n <= 1'b1;
    cpu_byte_strobe_n <= 2'b11;
    cpu_int_ack       <= 1'b0;
    repeat (5) @(posedge mclk);
  endtask

  task automatic tally_and_finish;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge mclk);
    n_mismatch++;
    tally_and_finish;
  end
  ////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {resetn, irq_req, ack_mute, cpu_word_addr, cpu_int_ack} = '0;
    {backplane_space_select, cpu_addr_strobe_n, cpu_data_strobe_n} = 3'h3;
    cpu_byte_strobe_n = 2'b11;
    ack_delay = 8'h03;
    done_delay = 8'h0A;
    n_mismatch = 0;
    n_compared = 0;
    repeat (10) @(posedge mclk);
    chk(32'(rom_pair_sel_n), 32'hFF);
    chk({30'h0, bus_request_n, bus_grant_n}, 32'h2);
    resetn <= 1'b1;
    n = 0;
    while (cpu_reset_n !== 1'b0 && n < 40) begin
      @(posedge mclk);
      n++;
    end
    n = 0;
    while (cpu_reset_n === 1'b0 && n < 40) begin
      @(posedge mclk);
      n++;
    end
    chk(32'(n), 32'd8);
    apb(`PBG_ADDR_STATUS, 1'b0, 32'h0);
    chk(rd & 32'h8, 32'h0);
    apb(`PBG_ADDR_MASK, 1'b0, 32'h0);
    chk(rd, 32'h0);
    $display("test reset done");
    for (int i = 1; i <= 7; i++) begin
      irq_req <= 7'((1 << i) - 1);
      repeat (6) @(posedge mclk);
      chk(32'(cpu_irq_level), 32'(i));
      apb(`PBG_ADDR_MASK, 1'b1, 32'(1 << (i - 1)));
      apb(`PBG_ADDR_MASK, 1'b0, 32'h0);
      chk(rd, 32'(1 << (i - 1)));
      chk(32'(cpu_irq_level), 32'(i - 1));
      apb(`PBG_ADDR_MASK, 1'b1, 32'h0);
    end
    apb(`PBG_ADDR_MASK, 1'b1, 32'h7F);
    repeat (2) @(posedge mclk);
    chk(32'(cpu_irq_level), 32'h0);
    apb(`PBG_ADDR_MASK, 1'b1, 32'h0);
    irq_req <= 7'h00;
    $display("test priority done");
    for (int k = 0; k < 3; k++) begin
      apb(8'(`PBG_ADDR_CTC0 + 4 * k), 1'b1, 32'h0001_0010);
      repeat (40) @(posedge mclk);
      apb(8'(`PBG_ADDR_CTC0 + 4 * k), 1'b0, 32'h0);
      chk(32'(rd[15:0] <= 16'h0010), 32'h1);
      apb(`PBG_ADDR_CTC_ACK, 1'b0, 32'h0);
      chk(rd & 32'h7, 32'(1 << k));
      chk(32'(cpu_irq_level), 32'h6);
      apb(8'(`PBG_ADDR_CTC0 + 4 * k), 1'b1, 32'h0);
      apb(`PBG_ADDR_CTC_ACK, 1'b1, 32'h7);
      repeat (5) @(posedge mclk);
      apb(`PBG_ADDR_CTC_ACK, 1'b0, 32'h0);
      chk(rd & 32'h7, 32'h0);
      chk(32'(cpu_irq_level), 32'h0);
    end
    $display("test counters done");
    for (int k = 0; k < 8; k++) begin
      cpu(1'b0, {4'h0, 3'(k), 15'h0}, 1'b1, 1'b0);
      chk(32'(rom_pair_sel_n), {24'h0, ~(8'h01 << k)});
      chk({buf_en_n, 3'h0, cpu_ack_n}, 32'h70);
      idle;
    end
    cpu(1'b0, 22'h0, 1'b0, 1'b0);
    chk({buf_en_n, byte_lane_en_n}, 32'h2E);
    idle;
    for (int f = 0; f < 4; f++) begin
      cpu(1'b0, {2'h0, 1'b1, 3'h0, 3'(f), 13'h0}, 1'b1, 1'b0);
      chk({ram_pair_sel_n, mask_latch_sel_n, ctc_sel_n}, 32'(ram_exp[f]));
      chk(32'(rom_pair_sel_n), 32'hFF);
      idle;
    end
    $display("test decode done");
    cpu(1'b1, 22'h0, 1'b1, 1'b0);
    chk({buf_en_n, rom_pair_sel_n, cpu_ack_n, bus_fault}, 32'h37FC);
    idle;
    ack_mute <= 1'b1;
    cpu(1'b1, 22'h0, 1'b1, 1'b0);
    repeat (12) @(posedge mclk);
    chk({cpu_ack_n, bus_fault}, 32'h3);
    idle;
    ack_mute <= 1'b0;
    chk(32'(bus_fault), 32'h0);
    apb(`PBG_ADDR_STATUS, 1'b0, 32'h0);
    chk(rd & 32'h4, 32'h4);
    apb(`PBG_ADDR_STATUS, 1'b1, 32'h4);
    apb(`PBG_ADDR_STATUS, 1'b0, 32'h0);
    chk(rd & 32'h4, 32'h0);
    cpu(1'b0, '1, 1'b1, 1'b1);
    chk(32'(cpu_autovector_n), 32'h0);
    idle;
    $display("test backplane done");
    apb(`PBG_ADDR_CTRL, 1'b1, 32'h1);
    repeat (2) @(posedge mclk);
    chk(32'(acquire_run_bit), 32'h1);
    n = 0;
    while (copy_start !== 1'b1 && n < 100) begin
      @(posedge mclk);
      n++;
    end
    chk({copy_start, acquire_run_bit}, 32'h2);
    apb(`PBG_ADDR_STATUS, 1'b0, 32'h0);
    chk(rd & 32'h3, 32'h2);
    apb(8'h40, 1'b0, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    chk({30'h0, bus_request_n, bus_grant_n}, 32'h2);
    $display("test acquisition done");
    tally_and_finish;
  end
endmodule
